// *** inc/sio_pkg.sv ***
// constants and types shared by the clocked serial port
package sio_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] SIO_IDX_PIN_FN   = 8'h04;
    localparam logic [7:0] SIO_IDX_MODE     = 8'h05;
    localparam logic [7:0] SIO_IDX_DATA_LO  = 8'h06;
    localparam logic [7:0] SIO_IDX_DATA_HI  = 8'h07;
    localparam logic [7:0] SIO_IDX_PRE_IDLE = 8'h25;
    localparam logic [7:0] SIO_IDX_CTRL     = 8'h30;
    localparam logic [7:0] SIO_IDX_STATUS   = 8'h31;
    localparam int         SIO_ADDR_W       = 12;

    // field positions
    localparam int SIO_PF_TX      = 0;
    localparam int SIO_PF_RX      = 1;
    localparam int SIO_MD_SCK_PIN = 3;
    localparam int SIO_PC_RANGE   = 0;
    localparam int SIO_PC_IDLE    = 1;
    localparam int SIO_CT_START   = 0;
    localparam int SIO_CT_CLR     = 1;

    // encodings and reset values
    localparam logic [1:0]  SIO_OP_CONT     = 2'h0;
    localparam logic [2:0]  SIO_CS_SYSCLK   = 3'h6;
    localparam logic [2:0]  SIO_CS_EXT      = 3'h7;
    localparam logic [3:0]  SIO_NIB_RST     = 4'h0;
    localparam logic [7:0]  SIO_DATA_RST    = 8'h00;
    localparam logic [2:0]  SIO_CNT_ZERO    = 3'h0;
    localparam logic [2:0]  SIO_CNT_LAST    = 3'h7;
    localparam logic [1:0]  SIO_BLOCK_CYC   = 2'h2;
    localparam logic [12:0] SIO_DIV_SYSCLK  = 13'h0001;
    localparam logic [12:0] SIO_DIV_TOP     = 13'h1000;
    localparam logic [12:0] SIO_DIV_ONE     = 13'h0001;

    typedef enum logic [3:0] {
        SIO_ST_START_WAIT = 4'b0001,
        SIO_ST_CLK_WAIT   = 4'b0010,
        SIO_ST_XFER       = 4'b0100,
        SIO_ST_CONT       = 4'b1000
    } sio_state_t;

    // half period of the internal transmit clock in MCLK cycles
    function automatic logic [12:0] sio_half_period(input logic range_bit,
                                                    input logic [2:0] sel);
        logic [12:0] d;
        d = SIO_DIV_TOP >> {sel[1:0], 1'b0};
        if (sel[2]) begin
            d = d >> 8;
        end
        if (!range_bit) begin
            d = d >> 1;
        end
        if (sel == SIO_CS_SYSCLK) begin
            d = SIO_DIV_SYSCLK;
        end
        return d;
    endfunction : sio_half_period

    // true for every mapped register index
    function automatic logic sio_reg_hit(input logic [SIO_ADDR_W-1:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        return (addr[1:0] == 2'h0) && (addr[SIO_ADDR_W-1:10] == 2'h0)
            && (idx == SIO_IDX_PIN_FN || idx == SIO_IDX_MODE
            || idx == SIO_IDX_DATA_LO || idx == SIO_IDX_DATA_HI
            || idx == SIO_IDX_PRE_IDLE || idx == SIO_IDX_CTRL
            || idx == SIO_IDX_STATUS);
    endfunction : sio_reg_hit
endpackage : sio_pkg

// *** hw/sio_clkgen.sv ***
// internal transmit clock generator: divides MCLK, idles high
`timescale 1ns/1ps
module sio_clkgen
    import sio_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // control
    input  wire logic        run,
    input  wire logic [12:0] half_period,
    // transmit clock
    output logic             sck_lvl,
    output logic             fall,
    output logic             rise
);
    typedef struct packed {
        logic [12:0] cnt;
        logic        lvl;
        logic        fall;
        logic        rise;
    } sio_gen_t;

    sio_gen_t r_reg;
    sio_gen_t r_next;

    always_comb begin
        r_next      = r_reg;
        r_next.fall = 1'b0;
        r_next.rise = 1'b0;
        if (!run) begin
            r_next.cnt = 13'h0000;
            r_next.lvl = 1'b1;
        end else if (r_reg.cnt + SIO_DIV_ONE >= half_period) begin
            r_next.cnt  = 13'h0000;
            r_next.lvl  = !r_reg.lvl;
            r_next.fall = r_reg.lvl;
            r_next.rise = !r_reg.lvl;
        end else begin
            r_next.cnt = r_reg.cnt + SIO_DIV_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r_reg <= '{cnt: 13'h0000, lvl: 1'b1, fall: 1'b0, rise: 1'b0};
        end else begin
            r_reg <= r_next;
        end
    end

    assign sck_lvl = r_reg.lvl;
    assign fall    = r_reg.fall;
    assign rise    = r_reg.rise;
endmodule : sio_clkgen

// *** hw/sio_port.sv ***
// clocked 8-bit serial port with APB register access
`timescale 1ns/1ps

// Overview of operation
// [RL1] pin-function low bits pick continuous, transmit, receive or both
// [RL2] any mode register write initialises the port; software writes it on mode change
// [RL3] mode register sets clock pin; pin-function register sets data pins
// [RL4] data register writes load transmit data, reads give received data
// [RL5] serial output undefined after reset until first bit or idle level write
// [RL6] start clears bit counter; counter advances on each transmit clock rise
// [RL7] eighth clock or abort clears counter, sets flag, stops transfer
// [RL8] prescaler range and three mode bits pick divider; period twice divider
// [RL9] reset gives start-wait, clocks ignored; start goes to clock-wait
// [RL10] first clock in clock-wait enters transfer, or continuous when internal mode 00
// [RL11] mode write during clock-wait returns to start-wait
// [RL12] start during transfer clears counter and returns to clock-wait
// [RL13] after eight clocks: external to clock-wait, internal to start-wait, clock stops
// [RL14] mode write during transfer initialises and returns to start-wait
// [RL15] leaving transfer for any state sets the flag
// [RL16] continuous state only drives clock pin; mode write returns to start-wait
// [RL17] idle states drive idle level on serial output; ignored while transferring
// [RL18] transfer spans first clock fall to eighth clock rise
// [RL19] spurious extra external pulse is revealed by flag setting again
// [RL20] data leaves LSB first on falls, enters LSB first on rises
// [RL21] mode write blocks the clock two cycles and clears the counter
// [RL22] software leaves prescaler control alone while transferring
// [RL23] internal mode is any clock selection other than the pin input
// [RL24] external clock is synchronised and edge detected before use
module sio_port
    import sio_pkg::*;
(
    // system
    input  wire logic                  MCLK,
    input  wire logic                  RST_N,
    // apb slave
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [SIO_ADDR_W-1:0] PADDR,
    input  wire logic [31:0]           PWDATA,
    output logic      [31:0]           PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    // serial clock pin
    input  wire logic                  SCK_I,
    output logic                       SCK_O,
    output logic                       SCK_OE,
    // serial data pins
    input  wire logic                  SI,
    output logic                       SO_O,
    output logic                       SO_OE
);
    typedef struct packed {
        sio_state_t  state;
        logic [3:0]  pin_fn;
        logic [3:0]  mode;
        logic [3:0]  pre_idle;
        logic [7:0]  shreg;
        logic [2:0]  cnt;
        logic        flag;
        logic        so_valid;
        logic [1:0]  blk;
        logic        sck_s1;
        logic        sck_s2;
        logic        sck_s3;
        logic        si_s1;
        logic        si_s2;
        logic        so_o;
        logic        so_oe;
        logic        sck_o;
        logic        sck_oe;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } sio_regs_t;

    localparam sio_regs_t SIO_REGS_RST = '{
        state:    SIO_ST_START_WAIT,
        pin_fn:   SIO_NIB_RST,
        mode:     SIO_NIB_RST,
        pre_idle: SIO_NIB_RST,
        shreg:    SIO_DATA_RST,
        cnt:      SIO_CNT_ZERO,
        flag:     1'b0,
        so_valid: 1'b0,
        blk:      2'h0,
        sck_s1:   1'b1,
        sck_s2:   1'b1,
        sck_s3:   1'b1,
        si_s1:    1'b0,
        si_s2:    1'b0,
        so_o:     1'b0,
        so_oe:    1'b0,
        sck_o:    1'b1,
        sck_oe:   1'b0,
        prdata:   32'h00000000,
        pready:   1'b0,
        pslverr:  1'b0
    };

    sio_regs_t r_reg;
    sio_regs_t r_next;

    logic        internal_clk;
    logic        gen_run;
    logic [12:0] gen_half;
    logic        gen_lvl;
    logic        gen_fall;
    logic        gen_rise;

    assign internal_clk = (r_reg.mode[2:0] != SIO_CS_EXT); // RL23
    assign gen_half     = sio_half_period(r_reg.pre_idle[SIO_PC_RANGE], r_reg.mode[2:0]); // RL8
    assign gen_run      = internal_clk && (r_reg.blk == 2'h0)
                       && (r_reg.state != SIO_ST_START_WAIT); // RL13

    sio_clkgen u_clkgen (
        .clk         (MCLK),
        .rst_n       (RST_N),
        .run         (gen_run),
        .half_period (gen_half),
        .sck_lvl     (gen_lvl),
        .fall        (gen_fall),
        .rise        (gen_rise)
    );

    always_comb begin
        logic       ev_fall;
        logic       ev_rise;
        logic       access;
        logic       wr;
        logic [7:0] idx;
        logic       mode_wr;
        logic       start;
        logic       clr;
        logic       set_flag;
        logic       tx_en;
        logic       rx_en;

        ev_fall = 1'b0;
        ev_rise = 1'b0;
        r_next  = r_reg;

        // two-stage synchronisers, third stage for edge detection
        r_next.sck_s1 = SCK_I; // RL24
        r_next.sck_s2 = r_reg.sck_s1;
        r_next.sck_s3 = r_reg.sck_s2;
        r_next.si_s1  = SI;
        r_next.si_s2  = r_reg.si_s1;

        // transmit clock edges, blocked right after a mode write
        if (internal_clk) begin
            ev_fall = gen_fall;
            ev_rise = gen_rise;
        end else begin
            ev_fall = r_reg.sck_s3 && !r_reg.sck_s2; // RL24
            ev_rise = !r_reg.sck_s3 && r_reg.sck_s2;
        end
        if (r_reg.blk != 2'h0) begin
            ev_fall = 1'b0; // RL21
            ev_rise = 1'b0;
            r_next.blk = r_reg.blk - 2'h1;
        end

        // apb: one wait state, answer registered
        idx     = PADDR[9:2];
        access  = PSEL && PENABLE && !r_reg.pready;
        wr      = PSEL && PENABLE && r_reg.pready && PWRITE && sio_reg_hit(PADDR);
        mode_wr = wr && (idx == SIO_IDX_MODE);
        start   = wr && (idx == SIO_IDX_CTRL) && PWDATA[SIO_CT_START];
        clr     = wr && (idx == SIO_IDX_CTRL) && PWDATA[SIO_CT_CLR];

        r_next.pready  = access;
        r_next.pslverr = access && !sio_reg_hit(PADDR);
        r_next.prdata  = 32'h00000000;
        if (access && !PWRITE && sio_reg_hit(PADDR)) begin
            case (idx)
                SIO_IDX_DATA_LO: r_next.prdata[3:0] = r_reg.shreg[3:0]; // RL4
                SIO_IDX_DATA_HI: r_next.prdata[3:0] = r_reg.shreg[7:4];
                SIO_IDX_STATUS:  r_next.prdata[8:0] = {r_reg.state, r_reg.cnt,
                                                       r_reg.blk != 2'h0, r_reg.flag};
                default:         r_next.prdata = 32'h00000000;
            endcase
        end

        if (wr && sio_reg_hit(PADDR)) begin
            case (idx)
                SIO_IDX_PIN_FN:   r_next.pin_fn = PWDATA[3:0]; // RL1
                SIO_IDX_MODE:     r_next.mode = PWDATA[3:0]; // RL3
                SIO_IDX_DATA_LO:  r_next.shreg[3:0] = PWDATA[3:0]; // RL4
                SIO_IDX_DATA_HI:  r_next.shreg[7:4] = PWDATA[3:0];
                SIO_IDX_PRE_IDLE: begin
                    r_next.pre_idle = PWDATA[3:0];
                    r_next.so_valid = 1'b1; // RL5
                end
                default: r_next.pin_fn = r_next.pin_fn;
            endcase
        end

        tx_en    = r_reg.pin_fn[SIO_PF_TX];
        rx_en    = r_reg.pin_fn[SIO_PF_RX];
        set_flag = 1'b0;

        // state machine: mode write, then start, then clock edges
        if (mode_wr) begin
            r_next.cnt   = SIO_CNT_ZERO; // RL21
            r_next.blk   = SIO_BLOCK_CYC;
            r_next.state = SIO_ST_START_WAIT; // RL2 RL11 RL16
            if (r_reg.state == SIO_ST_XFER) begin
                set_flag = 1'b1; // RL14 RL15 RL19
            end
        end else if (start) begin
            r_next.cnt = SIO_CNT_ZERO; // RL6
            case (r_reg.state)
                SIO_ST_START_WAIT: r_next.state = SIO_ST_CLK_WAIT; // RL9
                SIO_ST_XFER: begin
                    r_next.state = SIO_ST_CLK_WAIT; // RL12
                    set_flag     = 1'b1; // RL7 RL15
                end
                SIO_ST_CLK_WAIT:   r_next.state = SIO_ST_CLK_WAIT;
                SIO_ST_CONT:       r_next.state = SIO_ST_CONT;
                default:           r_next.state = SIO_ST_START_WAIT;
            endcase
        end else begin
            case (r_reg.state)
                SIO_ST_START_WAIT: r_next.cnt = SIO_CNT_ZERO; // RL9
                SIO_ST_CLK_WAIT: begin
                    if (ev_fall) begin
                        if (internal_clk && r_reg.pin_fn[1:0] == SIO_OP_CONT) begin
                            r_next.state = SIO_ST_CONT; // RL10 RL16
                        end else begin
                            r_next.state = SIO_ST_XFER; // RL10 RL18
                            r_next.so_o  = r_reg.shreg[0]; // RL20
                            if (tx_en) begin
                                r_next.so_valid = 1'b1; // RL5
                            end
                        end
                    end
                end
                SIO_ST_XFER: begin
                    if (ev_fall) begin
                        r_next.so_o = r_reg.shreg[0]; // RL20
                    end
                    if (ev_rise) begin
                        r_next.cnt   = r_reg.cnt + 3'h1; // RL6
                        r_next.shreg = {rx_en ? r_reg.si_s2 : 1'b0, r_reg.shreg[7:1]}; // RL20
                        if (r_reg.cnt == SIO_CNT_LAST) begin
                            set_flag = 1'b1; // RL7 RL15
                            if (internal_clk) begin
                                r_next.state = SIO_ST_START_WAIT; // RL13
                            end else begin
                                r_next.state = SIO_ST_CLK_WAIT; // RL13 RL19
                            end
                        end
                    end
                end
                SIO_ST_CONT:       r_next.cnt = SIO_CNT_ZERO; // RL16
                default:           r_next.state = SIO_ST_START_WAIT;
            endcase
        end

        // idle level follows the control bit outside transfer
        if (r_next.state != SIO_ST_XFER) begin
            r_next.so_o = r_next.pre_idle[SIO_PC_IDLE]; // RL17
        end

        // flag: a set in the same cycle as a clear wins
        r_next.flag = (r_reg.flag && !clr) || set_flag;

        r_next.so_oe  = r_next.pin_fn[SIO_PF_TX] && r_next.so_valid; // RL3 RL5
        r_next.sck_oe = r_reg.mode[SIO_MD_SCK_PIN] && internal_clk; // RL3 RL23
        r_next.sck_o  = internal_clk ? gen_lvl : 1'b1;
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            r_reg <= SIO_REGS_RST; // RL9
        end else begin
            r_reg <= r_next;
        end
    end

    assign PRDATA  = r_reg.prdata;
    assign PREADY  = r_reg.pready;
    assign PSLVERR = r_reg.pslverr;
    assign SCK_O   = r_reg.sck_o;
    assign SCK_OE  = r_reg.sck_oe;
    assign SO_O    = r_reg.so_o;
    assign SO_OE   = r_reg.so_oe;
endmodule : sio_port

// *** verif/sio_port_monitor.sv ***
// assertion checker watching the serial port pins
`timescale 1ns/1ps
module sio_port_monitor
    import sio_pkg::*;
(
    // system
    input wire logic                  MCLK,
    input wire logic                  RST_N,
    // apb
    input wire logic                  PSEL,
    input wire logic                  PENABLE,
    input wire logic                  PWRITE,
    input wire logic [SIO_ADDR_W-1:0] PADDR,
    input wire logic [31:0]           PWDATA,
    input wire logic [31:0]           PRDATA,
    input wire logic                  PREADY,
    input wire logic                  PSLVERR,
    // link
    input wire logic                  SCK_O,
    input wire logic                  SCK_OE,
    input wire logic                  SO_O,
    input wire logic                  SO_OE
);
    logic [3:0] mode_q;
    logic [1:0] pf_q;
    logic [3:0] cnt_q;
    logic       idle_q;
    logic       sck_q;
    wire  [7:0] ix    = PADDR[9:2];
    wire        take  = PSEL && PENABLE && PREADY && PWRITE;
    wire        pc_wr = take && ix == SIO_IDX_PRE_IDLE;
    wire        oe_ok = mode_q[SIO_MD_SCK_PIN] && mode_q[2:0] != SIO_CS_EXT;
    wire        hit   = PADDR[1:0] == 2'h0 && PADDR[11:10] == 2'h0 && ix inside {SIO_IDX_PIN_FN,
        SIO_IDX_MODE, SIO_IDX_DATA_LO, SIO_IDX_DATA_HI, SIO_IDX_PRE_IDLE, SIO_IDX_CTRL,
        SIO_IDX_STATUS};
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    // counts driven clock falls since the last start or mode write
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            mode_q <= 4'h0;
            pf_q   <= 2'h0;
            cnt_q  <= 4'h0;
            idle_q <= 1'b0;
            sck_q  <= 1'b1;
        end else begin
            sck_q <= SCK_O;
            if (take && ix == SIO_IDX_MODE) mode_q <= PWDATA[3:0];
            if (take && ix == SIO_IDX_PIN_FN) pf_q <= PWDATA[1:0];
            if (pc_wr) idle_q <= PWDATA[SIO_PC_IDLE];
            if (take && (ix == SIO_IDX_MODE || (ix == SIO_IDX_CTRL && PWDATA[SIO_CT_START])))
                cnt_q <= 4'h0;
            else if (SCK_OE && sck_q && !SCK_O && cnt_q != 4'hF)
                cnt_q <= cnt_q + 4'h1;
        end
    end
    sequence s_setup; PSEL && !PENABLE ##1 PSEL && PENABLE; endsequence
    sequence s_mode_wr; take && ix == SIO_IDX_MODE; endsequence
    property p_ready; s_setup |-> !PREADY ##1 PREADY; endproperty
    a_ready: assert property (p_ready) else $error("ready not after one wait state");
    property p_pulse; PREADY |=> !PREADY; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_err; PSEL && PENABLE && PREADY |-> PSLVERR == !hit && (hit || PRDATA == 0); endproperty
    a_err: assert property (p_err) else $error("error response wrong");
    property p_rst; $rose(RST_N) |-> SCK_O && !SCK_OE && !SO_OE && !PREADY; endproperty
    a_rst: assert property (p_rst) else $error("pins wrong after reset");
    property p_mode; s_mode_wr |=> ##2 SCK_O [*2]; endproperty
    a_mode: assert property (p_mode) else $error("clock not stopped by mode write");
    property p_idle; pc_wr |=> ##[0:1] SO_O == idle_q; endproperty
    a_idle: assert property (p_idle) else $error("idle level not applied");
    property p_cnt; pf_q != SIO_OP_CONT |-> cnt_q <= 4'h8; endproperty
    a_cnt: assert property (p_cnt) else $error("more than eight clocks driven");
    property p_oe; SCK_OE |-> oe_ok || $past(oe_ok) || $past(oe_ok, 2); endproperty
    a_oe: assert property (p_oe) else $error("clock pin driven in external mode");
    property p_sooe; SO_OE |-> pf_q[SIO_PF_TX] || $past(pf_q[SIO_PF_TX], 2); endproperty
    a_sooe: assert property (p_sooe) else $error("output driven without transmit");
endmodule : sio_port_monitor

bind sio_port sio_port_monitor u_mon (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SCK_O(SCK_O), .SCK_OE(SCK_OE), .SO_O(SO_O), .SO_OE(SO_OE));

// *** verif/sio_peer.sv ***
// behavioural serial device on the far side of the link
`timescale 1ns/1ps
module sio_peer (
    // timing
    input  wire logic clk,
    // link
    input  wire logic sck,
    input  wire logic so,
    output logic      si,
    output logic      ext_sck
);
    logic [7:0] tx;
    logic [7:0] rx;
    int         falls;
    int         per;
    time        last;
    logic       sck_q;
    logic       so_q;
    initial begin
        sck_q   = 1'b1;
        so_q    = 1'b0;
        si      = 1'b0;
        ext_sck = 1'b1;
        tx      = 8'h00;
        rx      = 8'h00;
        falls   = 0;
        per     = 0;
        last    = 0;
    end
    // spent bits return inverted so a stale line never looks valid
    always @(negedge sck) begin
        si    <= tx[0];
        tx    <= {~tx[0], tx[7:1]};
        falls <= falls + 1;
        per   <= int'(($time - last) / 100);
        last  <= $time;
    end
    // take the data line as it stood just before each clock rise
    always @(posedge clk) begin
        sck_q <= sck;
        so_q  <= so;
        if (sck && !sck_q) begin
            rx <= {so_q, rx[7:1]};
        end
    end
    // external clock idles high and moves only inside a burst
    task pulses(input int n);
        repeat (n) begin
            repeat (10) @(posedge clk);
            ext_sck <= 1'b0;
            repeat (10) @(posedge clk);
            ext_sck <= 1'b1;
        end
        repeat (10) @(posedge clk);
    endtask : pulses
endmodule : sio_peer

// *** verif/tb.sv ***
// self-checking testbench for the clocked serial port
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %s expected %0h seen %0h", n, e, g); end end
module tb;
    import sio_pkg::*;
    logic        MCLK, RST_N, PSEL, PENABLE, PWRITE, SI, SCK_O, SCK_OE, SO_O, SO_OE;
    logic        PREADY, PSLVERR, rerr, ext_sck;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rdata;
    int          bad_count, cmp_count;
    int          per_exp [4] = '{16, 4, 8, 2};
    wire         sck_line = SCK_OE ? SCK_O : ext_sck;
    wire         so_line  = SO_OE ? SO_O : ~SO_O;
    sio_port DUT (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
        .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .SCK_I(sck_line), .SCK_O(SCK_O), .SCK_OE(SCK_OE), .SI(SI), .SO_O(SO_O), .SO_OE(SO_OE));
    sio_peer peer (.clk(MCLK), .sck(sck_line), .so(so_line), .si(SI), .ext_sck(ext_sck));
    initial begin
        MCLK = 1'b0;
        forever #50 MCLK = ~MCLK;
    end
    task automatic apb(input logic w, input logic [7:0] i, input logic [3:0] d);
        int k;
        @(posedge MCLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= w;
        PADDR   <= {2'h0, i, 2'h0};
        PWDATA  <= {28'h0, d};
        @(posedge MCLK);
        PENABLE <= 1'b1;
        k = 0;
        do @(posedge MCLK); while (PREADY !== 1'b1 && ++k < 20);
        if (PREADY !== 1'b1) begin
            bad_count++;
        end
        rdata = PRDATA;
        rerr  = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic st(input sio_state_t s, input logic [2:0] c, input logic f);
        logic [8:0] e;
        e = {s, c, 1'b0, f};
        apb(1'b0, SIO_IDX_STATUS, 4'h0);
        `CHK("status", e, rdata[8:0] & 9'h1FD)
    endtask : st
    task end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20000) @(posedge MCLK);
        bad_count++;
        end_of_test;
    end
    initial begin
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA, RST_N} = '0;
        bad_count = 0;
        cmp_count = 0;
        repeat (2) @(posedge MCLK);
        RST_N <= 1'b1;
        st(SIO_ST_START_WAIT, 3'h0, 1'b0);
        apb(1'b0, SIO_IDX_DATA_LO, 4'h0);
        `CHK("data_reset", 32'h0, rdata)
        `CHK("so_oe_reset", 1'b0, SO_OE)
        apb(1'b0, 8'h08, 4'h0);
        `CHK("unmapped_err", 1'b1, rerr)
        apb(1'b1, SIO_IDX_PIN_FN, 4'h3);
        for (int v = 1; v >= 0; v--) begin
            apb(1'b1, SIO_IDX_PRE_IDLE, {2'h0, v[0], 1'b0});
            repeat (2) @(negedge MCLK);
            `CHK("so_idle", v[0], SO_O)
            `CHK("so_oe_idle", 1'b1, SO_OE)
        end
        apb(1'b1, SIO_IDX_MODE, 4'hC);
        peer.tx = 8'h3C;
        peer.falls = 0;
        apb(1'b1, SIO_IDX_DATA_LO, 4'h5);
        apb(1'b1, SIO_IDX_DATA_HI, 4'hA);
        apb(1'b1, SIO_IDX_CTRL, 4'h1);
        for (int n = 0; n < 200 && rdata[0] !== 1'b1; n++) apb(1'b0, SIO_IDX_STATUS, 4'h0);
        st(SIO_ST_START_WAIT, 3'h0, 1'b1);
        apb(1'b0, SIO_IDX_DATA_HI, 4'h0);
        `CHK("rx_high", 32'h3, rdata)
        apb(1'b0, SIO_IDX_DATA_LO, 4'h0);
        `CHK("rx_low", 32'hC, rdata)
        `CHK("tx_byte", 8'hA5, peer.rx)
        `CHK("clock_count", 8, peer.falls)
        apb(1'b1, SIO_IDX_CTRL, 4'h2);
        apb(1'b1, SIO_IDX_MODE, 4'h7);
        apb(1'b1, SIO_IDX_CTRL, 4'h1);
        st(SIO_ST_CLK_WAIT, 3'h0, 1'b0);
        `CHK("sck_oe_ext", 1'b0, SCK_OE)
        peer.pulses(1);
        st(SIO_ST_XFER, 3'h1, 1'b0);
        peer.pulses(7);
        st(SIO_ST_CLK_WAIT, 3'h0, 1'b1);
        peer.pulses(1);
        st(SIO_ST_XFER, 3'h1, 1'b1);
        apb(1'b1, SIO_IDX_CTRL, 4'h2);
        apb(1'b1, SIO_IDX_MODE, 4'h7);
        st(SIO_ST_START_WAIT, 3'h0, 1'b1);
        apb(1'b1, SIO_IDX_CTRL, 4'h1);
        apb(1'b1, SIO_IDX_MODE, 4'h7);
        st(SIO_ST_START_WAIT, 3'h0, 1'b1);
        apb(1'b1, SIO_IDX_CTRL, 4'h2);
        apb(1'b1, SIO_IDX_CTRL, 4'h1);
        peer.pulses(2);
        apb(1'b1, SIO_IDX_CTRL, 4'h1);
        st(SIO_ST_CLK_WAIT, 3'h0, 1'b1);
        apb(1'b1, SIO_IDX_MODE, 4'h7);
        apb(1'b1, SIO_IDX_PIN_FN, 4'h2);
        apb(1'b1, SIO_IDX_PRE_IDLE, 4'h2);
        repeat (2) @(negedge MCLK);
        `CHK("so_oe_rx_only", 1'b0, SO_OE)
        apb(1'b1, SIO_IDX_PIN_FN, 4'h0);
        for (int j = 0; j < 4; j++) begin
            apb(1'b1, SIO_IDX_PRE_IDLE, {3'h0, j[1]});
            apb(1'b1, SIO_IDX_MODE, (j == 3) ? 4'hE : {3'h6, j != 0});
            apb(1'b1, SIO_IDX_CTRL, 4'h1);
            repeat (60) @(posedge MCLK);
            apb(1'b0, SIO_IDX_STATUS, 4'h0);
            `CHK("continuous", SIO_ST_CONT, rdata[8:5])
            `CHK("period", per_exp[j], peer.per)
            `CHK("sck_oe_int", 1'b1, SCK_OE)
            apb(1'b1, SIO_IDX_MODE, 4'h4);
            apb(1'b0, SIO_IDX_STATUS, 4'h0);
            `CHK("cont_stop", SIO_ST_START_WAIT, rdata[8:5])
        end
        end_of_test;
    end
endmodule : tb
